/* design/usr_pkg.sv */
// Purpose: Shared constants and types of the universal shift register block
// Assumes: One 50 MHz system clock, Avalon-MM register slave
// Notes: Variant chosen at build time by a top-level parameter
package usr_pkg;
  localparam int USR_WIDTH = 8;
  localparam int USR_AW = 4;
  localparam int USR_DW = 32;
  localparam int USR_FIFO_DEPTH = 2;
  // Register byte offsets
  localparam logic [USR_AW-1:0] USR_OFS_CTRL = 4'h0;
  localparam logic [USR_AW-1:0] USR_OFS_STATUS = 4'h4;
  localparam logic [USR_AW-1:0] USR_OFS_EDGES = 4'h8;
  // Control fields
  localparam int USR_CTRL_SOFT_CLR = 0;
  localparam int USR_CTRL_ENABLE = 1;
  localparam logic [1:0] USR_CTRL_RESET = 2'h2;
  // Status fields
  localparam int USR_STAT_LEVEL_LSB = 8;
  localparam int USR_STAT_PEND = 10;
  localparam int USR_STAT_CLR = 11;
  localparam logic [USR_WIDTH-1:0] USR_STAGE_RESET = 8'h00;

  typedef enum logic [1:0] {
    USR_MODE_HOLD,
    USR_MODE_RIGHT,
    USR_MODE_LEFT,
    USR_MODE_LOAD
  } usr_mode_e;

  // Pin bundle, all arriving from outside the system clock
  typedef struct packed {
    logic clk_pin;
    logic clock_gate_input;
    logic async_clear_n;
    logic mode_select_high;
    logic mode_select_low;
    logic right_serial_input;
    logic left_serial_input;
    logic shift_or_load_select;
    logic set_input;
    logic hold_input_n;
    logic [USR_WIDTH-1:0] par_data;
  } usr_pins_s;

  localparam int USR_PINS_W = $bits(usr_pins_s);

  typedef struct packed {
    logic read;
    logic write;
    logic [USR_AW-1:0] address;
    logic [USR_DW-1:0] writedata;
    logic [3:0] byteenable;
  } usr_avs_req_s;
endpackage

/* design/usr_sync.sv */
// Purpose: Two-flop synchroniser for a bundle of pin inputs
// Assumes: Bits are quasi-static around the sampled edges
// Notes: First stage is read only by the second
module usr_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] d_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } usr_sync_s;

  usr_sync_s st_r;
  usr_sync_s st_nxt;

  always_comb begin
    st_nxt.meta = d_in;
    st_nxt.sync = st_r.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign d_out = st_r.sync;
endmodule

/* design/usr_fifo2.sv */
// Purpose: Two-entry buffer with valid/ready on both sides
// Assumes: Same clock on both sides
// Notes: Ready on the fill side drops when both entries hold data
module usr_fifo2 #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [1:0] level
);
  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic [1:0] count;
  } usr_fifo_s;

  usr_fifo_s st_r;
  usr_fifo_s st_nxt;
  logic push;
  logic pop;

  assign in_ready = (st_r.count != 2'h2);
  assign out_valid = (st_r.count != 2'h0);
  assign out_data = st_r.head;
  assign level = st_r.count;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    st_nxt = st_r;
    if (pop) begin
      st_nxt.head = st_r.tail;
    end
    if (push) begin
      if (st_r.count == 2'h0 || (st_r.count == 2'h1 && pop)) begin
        st_nxt.head = in_data;
      end else begin
        st_nxt.tail = in_data;
      end
    end
    st_nxt.count = st_r.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

/* design/usr_shift_top.sv */
// Purpose: Eight-stage universal shift register, two build variants
// Assumes: Device clock arrives as a pin and is sampled on clk_sys
// Notes: Every new register value is streamed out through a buffer, unless a clear overwrites it while its push is stalled
//
// Our own choices: register access over Avalon-MM and the register addresses.
module usr_shift_top
  import usr_pkg::*;
#(
  parameter bit GATED_VARIANT = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire usr_pkg::usr_pins_s pins,
  output logic [usr_pkg::USR_WIDTH-1:0] stage_out,
  output logic first_stage_output,
  output logic last_stage_output,
  output logic str_valid,
  input wire logic str_ready,
  output logic [usr_pkg::USR_WIDTH-1:0] str_data,
  input wire usr_pkg::usr_avs_req_s avs_req,
  output logic [usr_pkg::USR_DW-1:0] avs_readdata,
  output logic avs_waitrequest
);
  import usr_pkg::*;

  typedef struct packed {
    logic [USR_WIDTH-1:0] stage;
    logic prev_clk;
    logic pend;
    logic push;
    logic [1:0] ctrl;
    logic ack;
    logic [USR_DW-1:0] rdata;
    logic [USR_DW-1:0] edges;
    logic [1:0] settle;
  } usr_main_s;

  usr_main_s st_r;
  usr_main_s st_nxt;
  usr_pins_s ps;
  logic fifo_ready;
  logic [1:0] fifo_level;
  logic eff_clk;
  logic rise;
  logic clear;
  logic event_req;
  logic do_step;
  logic req;

  function automatic logic [USR_WIDTH-1:0] step_bidir(
    input logic [USR_WIDTH-1:0] q,
    input usr_mode_e mode,
    input logic sr,
    input logic sl,
    input logic [USR_WIDTH-1:0] d
  );
    logic [USR_WIDTH-1:0] r;
    r = q;
    case (mode)
      USR_MODE_LOAD: r = d;
      USR_MODE_RIGHT: r = {q[USR_WIDTH-2:0], sr};
      USR_MODE_LEFT: r = {sl, q[USR_WIDTH-1:1]};
      default: r = q;
    endcase
    return r;
  endfunction

  function automatic logic [USR_WIDTH-1:0] step_gated(
    input logic [USR_WIDTH-1:0] q,
    input logic shift,
    input logic set_in,
    input logic hold_n,
    input logic [USR_WIDTH-1:0] d
  );
    logic [USR_WIDTH-1:0] r;
    logic first;
    r = d;
    first = set_in ? (hold_n ? 1'b1 : ~q[0]) : (hold_n ? q[0] : 1'b0);
    if (shift) begin
      r = {q[USR_WIDTH-2:0], first};
    end
    return r;
  endfunction

  // Pins and device clock come from outside; same latency keeps data aligned
  usr_sync #(
    .W(USR_PINS_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d_in(pins),
    .d_out(ps)
  );

  usr_fifo2 #(
    .W(USR_WIDTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(st_r.push),
    .in_ready(fifo_ready),
    .in_data(st_r.stage),
    .out_valid(str_valid),
    .out_ready(str_ready),
    .out_data(str_data),
    .level(fifo_level)
  );

  // Either input high holds the combined clock high, so edges come from the other
  assign eff_clk = GATED_VARIANT ? (ps.clk_pin | ps.clock_gate_input) : ps.clk_pin;
  assign rise = eff_clk & ~st_r.prev_clk;
  // Synchroniser shows zeros just after reset; its clear level is not real yet
  assign clear = (st_r.settle[1] & ~ps.async_clear_n) | st_r.ctrl[USR_CTRL_SOFT_CLR];
  assign event_req = (rise | st_r.pend) & st_r.ctrl[USR_CTRL_ENABLE];
  // A stalled push into a full buffer defers the edge; inputs are then taken when it executes
  assign do_step = event_req & ~(st_r.push & ~fifo_ready);
  assign req = avs_req.read | avs_req.write;

  always_comb begin
    st_nxt = st_r;
    // Clock already high at reset is no edge
    st_nxt.prev_clk = eff_clk | ~st_r.settle[1];
    st_nxt.settle = {st_r.settle[0], 1'b1};
    st_nxt.push = st_r.push & ~fifo_ready;
    if (clear) begin
      st_nxt.stage = USR_STAGE_RESET;
      st_nxt.pend = 1'b0;
      st_nxt.push = (st_r.stage != USR_STAGE_RESET) | st_nxt.push;
    end else begin
      st_nxt.pend = event_req & ~do_step;
      if (do_step) begin
        st_nxt.push = 1'b1;
        st_nxt.edges = st_r.edges + 32'h0000_0001;
        if (GATED_VARIANT) begin
          st_nxt.stage = step_gated(st_r.stage, ps.shift_or_load_select,
                                    ps.set_input, ps.hold_input_n, ps.par_data);
        end else begin
          st_nxt.stage = step_bidir(st_r.stage,
                                    usr_mode_e'({ps.mode_select_high, ps.mode_select_low}),
                                    ps.right_serial_input, ps.left_serial_input,
                                    ps.par_data);
        end
      end
    end
    // Register slave: one wait cycle, then answer
    st_nxt.ack = req & ~st_r.ack;
    if (req && !st_r.ack) begin
      st_nxt.rdata = '0;
      if (avs_req.address == USR_OFS_CTRL) begin
        st_nxt.rdata[1:0] = st_r.ctrl;
      end else if (avs_req.address == USR_OFS_STATUS) begin
        st_nxt.rdata[USR_WIDTH-1:0] = st_r.stage;
        st_nxt.rdata[USR_STAT_LEVEL_LSB+1:USR_STAT_LEVEL_LSB] = fifo_level;
        st_nxt.rdata[USR_STAT_PEND] = st_r.pend;
        st_nxt.rdata[USR_STAT_CLR] = clear;
      end else if (avs_req.address == USR_OFS_EDGES) begin
        st_nxt.rdata = st_r.edges;
      end else begin
        st_nxt.rdata = '0;
      end
    end
    if (avs_req.write && st_r.ack && avs_req.byteenable[0]) begin
      if (avs_req.address == USR_OFS_CTRL) begin
        st_nxt.ctrl = avs_req.writedata[1:0];
      end else if (avs_req.address == USR_OFS_EDGES) begin
        st_nxt.edges = '0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
      st_r.ctrl <= USR_CTRL_RESET;
      st_r.stage <= USR_STAGE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Raw clear pin masks outputs so clearing does not wait for the synchroniser;
  // synced clear covers the gap until the flops are zero. Clear needs two cycles.
  assign stage_out = st_r.stage & {USR_WIDTH{pins.async_clear_n & ps.async_clear_n}};
  assign first_stage_output = stage_out[0];
  assign last_stage_output = stage_out[USR_WIDTH-1];
  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = req & ~st_r.ack;
endmodule

/* sim/usr_pin_drv.sv */
// Purpose: Surrounding logic driving the device pins
// Assumes: Tasks entered just after a clk_sys rising edge
// Notes: PHASE sets pin clock half period, slow enough for the synchroniser
module usr_pin_drv
  import usr_pkg::*;
#(
  parameter int PHASE = 4
) (
  input wire logic clk_sys,
  output usr_pkg::usr_pins_s pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pins = '0;
    pins.clk_pin = 1'b1;
    pins.async_clear_n = 1'b1;
  end
  task step(input logic [1:0] m, input logic sr, input logic sl, input logic [7:0] d);
    pins.mode_select_high <= m[1];
    pins.mode_select_low <= m[0];
    pins.right_serial_input <= sr;
    pins.left_serial_input <= sl;
    pins.par_data <= d;
    repeat (PHASE) @(posedge clk_sys);
    pins.clk_pin <= 1'b0;
    repeat (PHASE) @(posedge clk_sys);
    pins.clk_pin <= 1'b1;
    repeat (PHASE) @(posedge clk_sys);
  endtask
  task gstep(input logic shift, input logic j, input logic kn, input logic [7:0] d);
    pins.shift_or_load_select <= shift;
    pins.set_input <= j;
    pins.hold_input_n <= kn;
    step(2'h0, 1'b0, 1'b0, d);
  endtask
  task gate(input logic v);
    pins.clock_gate_input <= v;
    repeat (PHASE) @(posedge clk_sys);
  endtask
  task pin_clk(input logic v);
    pins.clk_pin <= v;
    repeat (PHASE) @(posedge clk_sys);
  endtask
  task clear(input logic v);
    pins.async_clear_n <= v;
    @(posedge clk_sys);
  endtask
endmodule

/* sim/usr_shift_props.sv */
// Purpose: Port-level assertions for the shift register top
// Assumes: Pins held steady four cycles around each pin clock edge
// Notes: Bound to both variants; gated build disables the mode checks
module usr_shift_props
  import usr_pkg::*;
#(
  parameter bit GATED_VARIANT = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire usr_pkg::usr_pins_s pins,
  input wire logic [usr_pkg::USR_WIDTH-1:0] stage_out,
  input wire logic first_stage_output,
  input wire logic last_stage_output,
  input wire logic str_valid,
  input wire logic str_ready,
  input wire logic [usr_pkg::USR_WIDTH-1:0] str_data,
  input wire usr_pkg::usr_avs_req_s avs_req,
  input wire logic avs_waitrequest
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence held(logic [1:0] m);
    (!GATED_VARIANT && pins.async_clear_n
      && {pins.mode_select_high, pins.mode_select_low} == m) [*4];
  endsequence
  sequence moved;
    $changed(stage_out);
  endsequence
  taps_a: assert property (first_stage_output == stage_out[0]
    && last_stage_output == stage_out[7]) else $error("tap outputs differ from stages");
  clear_now_a: assert property (!pins.async_clear_n |-> stage_out == 8'h00)
    else $error("stages not low during clear");
  clear_rel_a: assert property ($rose(pins.async_clear_n) |-> stage_out == 8'h00)
    else $error("stages not low after clear");
  load_a: assert property (held(2'h3) ##0 (moved and $past(pins.par_data, 3) == pins.par_data)
    |-> stage_out == pins.par_data) else $error("load value wrong");
  right_a: assert property (held(2'h1) ##0 moved
    |-> stage_out[7:1] == $past(stage_out[6:0])) else $error("right shift wrong");
  left_a: assert property (held(2'h2) ##0 moved
    |-> stage_out[6:0] == $past(stage_out[7:1])) else $error("left shift wrong");
  hold_a: assert property (held(2'h0) |=> $stable(stage_out) || !pins.async_clear_n)
    else $error("hold mode changed stages");
  stall_a: assert property (str_valid && !str_ready |=> str_valid && $stable(str_data))
    else $error("stalled word lost");
  wait_a: assert property ($rose(avs_req.read || avs_req.write)
    |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer timing wrong");
endmodule
bind usr_shift_top usr_shift_props #(.GATED_VARIANT(GATED_VARIANT)) usr_shift_props_inst (
  .clk_sys(clk_sys), .rst(rst), .pins(pins), .stage_out(stage_out),
  .first_stage_output(first_stage_output), .last_stage_output(last_stage_output),
  .str_valid(str_valid), .str_ready(str_ready), .str_data(str_data),
  .avs_req(avs_req), .avs_waitrequest(avs_waitrequest));

/* sim/tb.sv */
// Purpose: Self-checking bench, bidirectional and gated builds
// Assumes: Bus answers are awaited, never counted on
// Notes: Gated build shares the pins; budget spent on bus and stall
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import usr_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic str_ready = 1'b1;
  usr_avs_req_s req = '0;
  usr_pins_s pins;
  logic [7:0] stage_out, str_data, q, g_stage;
  logic fs, ls, str_valid, ws;
  logic [31:0] rd, avs_readdata;
  logic avs_waitrequest;
  int n_fail = 0;
  int comparisons = 0;
  int i, n;
  logic [1:0] md [6] = '{2'h3, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
  always #10 clk_sys = ~clk_sys;
  usr_pin_drv usr_pin_drv_inst (.clk_sys(clk_sys), .pins(pins));
  usr_shift_top #(.GATED_VARIANT(1'b0)) usr_shift_top_inst (.clk_sys(clk_sys), .rst(rst),
    .pins(pins), .stage_out(stage_out), .first_stage_output(fs), .last_stage_output(ls),
    .str_valid(str_valid), .str_ready(str_ready), .str_data(str_data), .avs_req(req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  // Gated build on the same pins; it ignores the bidirectional inputs
  if (1) begin : gated_blk
    usr_shift_top #(.GATED_VARIANT(1'b1)) usr_shift_top_inst (.clk_sys(clk_sys), .rst(rst),
      .pins(pins), .stage_out(g_stage), .first_stage_output(), .last_stage_output(),
      .str_valid(), .str_ready(str_ready), .str_data(), .avs_req('0),
      .avs_readdata(), .avs_waitrequest());
  end
  task final_report;
    $display("comparisons %0d failures %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task see(input logic [7:0] e, input bit g = 1'b0);
    @(negedge clk_sys);
    if (g) begin
      chk("gated stage", {24'h0, e}, {24'h0, g_stage});
    end else begin
      chk("stage", {24'h0, e}, {24'h0, stage_out});
    end
    @(posedge clk_sys);
  endtask
  // Settled values sampled mid-cycle; inputs only move after rising edges
  task acc(input logic w, input logic [3:0] a, input logic [31:0] wd);
    n = 0;
    req <= '{read: !w, write: w, address: a, writedata: wd, byteenable: 4'hF};
    do begin
      @(negedge clk_sys);
      ws = avs_waitrequest;
      rd = avs_readdata;
      n++;
      @(posedge clk_sys);
    end while (ws && n < 20);
    req <= '0;
    @(posedge clk_sys);
    if (ws) begin
      n_fail++;
      final_report();
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    acc(1'b0, USR_OFS_CTRL, 32'h0);
    chk("ctrl", 32'h2, rd);
    acc(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, rd);
    acc(1'b1, USR_OFS_EDGES, 32'h5);
    acc(1'b0, USR_OFS_EDGES, 32'h0);
    chk("edges", 32'h0, rd);
    q = 8'h00;
    for (i = 0; i < 6; i++) begin
      usr_pin_drv_inst.step(md[i], i[0], !i[0], 8'hA5 + 8'(i));
      case (md[i])
        2'h1: q = {q[6:0], i[0]};
        2'h2: q = {!i[0], q[7:1]};
        2'h3: q = 8'hA5;
        default: q = q;
      endcase
      see(q);
    end
    usr_pin_drv_inst.clear(1'b0);
    see(8'h00);
    usr_pin_drv_inst.clear(1'b1);
    repeat (4) @(posedge clk_sys);
    // Fourth edge must wait for buffer room, not vanish
    str_ready <= 1'b0;
    for (i = 1; i < 5; i++) begin
      usr_pin_drv_inst.step(2'h3, 1'b0, 1'b0, 8'(i * 17));
    end
    see(8'h33);
    acc(1'b0, USR_OFS_STATUS, 32'h0);
    chk("status", 32'h633, rd);
    str_ready <= 1'b1;
    i = 1;
    for (n = 0; i < 5 && n < 60; n++) begin
      @(negedge clk_sys);
      if (str_valid) begin
        chk("word", 32'(i * 17), {24'h0, str_data});
        i++;
      end
    end
    @(posedge clk_sys);
    chk("drained", 32'h5, i);
    see(8'h44);
    usr_pin_drv_inst.gstep(1'b0, 1'b1, 1'b0, 8'h5A);
    see(8'h5A, 1'b1);
    usr_pin_drv_inst.gstep(1'b1, 1'b1, 1'b1, 8'hFF);
    see(8'hB5, 1'b1);
    usr_pin_drv_inst.gstep(1'b1, 1'b0, 1'b0, 8'hFF);
    see(8'h6A, 1'b1);
    usr_pin_drv_inst.gstep(1'b1, 1'b0, 1'b1, 8'h00);
    see(8'hD4, 1'b1);
    usr_pin_drv_inst.gstep(1'b1, 1'b1, 1'b0, 8'h00);
    see(8'hA9, 1'b1);
    usr_pin_drv_inst.gate(1'b1);
    usr_pin_drv_inst.gstep(1'b1, 1'b1, 1'b1, 8'h00);
    see(8'hA9, 1'b1);
    // Roles swapped: clock pin held low, edges come from the gate input
    usr_pin_drv_inst.pin_clk(1'b0);
    usr_pin_drv_inst.gate(1'b0);
    usr_pin_drv_inst.gate(1'b1);
    see(8'h53, 1'b1);
    see(8'h44);
    usr_pin_drv_inst.pin_clk(1'b1);
    usr_pin_drv_inst.gate(1'b0);
    usr_pin_drv_inst.clear(1'b0);
    see(8'h00, 1'b1);
    usr_pin_drv_inst.clear(1'b1);
    see(8'h00, 1'b1);
    repeat (4) @(posedge clk_sys);
    final_report();
  end
endmodule
